// file: hdl/deser_bist_i2c_datapath_regs.sv
// Self test tally, master clock timing and datapath control registers
//
// Behaviour
// RQ1: Tally register reads the error count of the chosen port, writes ignored.
// RQ2: As master, SCL high lasts high-period counts of 50 ns each.
// RQ3: High period resets to 0x83, enough for 5us even at 26MHz.
// RQ4: As master, SCL low lasts low-period counts; resets to 0x84.
// RQ5: As slave, low period is the data setup before releasing stretched SCL.
// RQ6: Lock bit set blocks forward-channel loads; clear allows them.
// RQ7: Video-disabled resets to 1; control channel and pins keep working.
// RQ8: Dual-link bit reports serializer mode for data recovery.
// RQ9: Alternate audio puts word clock on pin one, data on pin zero.
// RQ10: 28-bit video bit marks sync and enable as carried in stream.
// RQ11: Surround bit enables surround audio handling.
// RQ12: Audio-disable bit mutes audio output; reserved bit 6 reads 0.
`timescale 1ns/1ps
module deser_bist_i2c_datapath_regs (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    input wire logic I_FC_LOAD,
    input wire logic [7:0] I_FC_DATA,
    input wire logic I_SECOND_PORT_CHOICE,
    input wire logic [7:0] I_TALLY_PORT0,
    input wire logic [7:0] I_TALLY_PORT1,
    input wire logic I_SCL_MASTER_EN,
    input wire logic I_SCL_IN,
    output logic O_SCL_O,
    output logic O_SCL_OE,
    input wire logic I_SLV_DATA_READY,
    output logic O_SLV_SCL_HOLD,
    input wire logic I_AUDIO_WCLK,
    input wire logic I_AUDIO_SDATA,
    input wire logic I_PIN_ZERO_NORMAL,
    input wire logic I_PIN_ONE_NORMAL,
    output logic O_GENERAL_PIN_ZERO,
    output logic O_GENERAL_PIN_ONE,
    output logic O_AUDIO_WCLK,
    output logic O_AUDIO_SDATA,
    output logic O_VIDEO_DISABLED,
    output logic O_DUAL_LINK,
    output logic O_SYNC_IN_STREAM,
    output logic O_SURROUND_EN,
    output logic O_CTRL_CHAN_EN
);
    import deser_regs_pkg::*;

    logic [7:0] high_ff, nxt_high;
    logic [7:0] low_ff, nxt_low;
    logic [7:0] dp_ff, nxt_dp;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic scl_level_ff, nxt_scl_level;
    logic pin0_ff, nxt_pin0;
    logic pin1_ff, nxt_pin1;
    logic awclk_ff, nxt_awclk;
    logic asdata_ff, nxt_asdata;
    logic ctrl_en_ff;
    logic [7:0] tally_sel;
    logic wr_high, wr_low, wr_dp;
    logic scl_drive_low;
    logic slv_hold;

    scl_timing_if tif ();

    // Address decode of the local register port
    assign wr_high = I_REG_WR && (I_REG_ADDR == ADDR_SCL_HIGH);
    assign wr_low = I_REG_WR && (I_REG_ADDR == ADDR_SCL_LOW);
    assign wr_dp = I_REG_WR && (I_REG_ADDR == ADDR_DP_CTRL2);

    // Port choice comes from logic on this clock, so no synchroniser
    assign tally_sel = I_SECOND_PORT_CHOICE ? I_TALLY_PORT1
                                            : I_TALLY_PORT0; // [RQ1]

    // Next values of the stored registers
    always_comb
    begin
        nxt_high = high_ff;
        nxt_low = low_ff;
        nxt_dp = dp_ff;
        if (wr_high)
        begin
            nxt_high = I_REG_WDATA; // [RQ2]
        end
        if (wr_low)
        begin
            nxt_low = I_REG_WDATA; // [RQ4]
        end
        // A local write beats a forward-channel load in the same cycle
        if (wr_dp)
        begin
            nxt_dp = I_REG_WDATA & DP_WRITE_MASK; // [RQ12]
        end
        else if (I_FC_LOAD && !dp_ff[BIT_LOCK])
        begin
            nxt_dp = (dp_ff & ~DP_FC_MASK)
                   | (I_FC_DATA & DP_FC_MASK); // [RQ6]
        end
    end

    // Register storage, reset values hold the documented defaults
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RESET_N)
        begin
            high_ff <= RST_SCL_HIGH; // [RQ3]
            low_ff <= RST_SCL_LOW; // [RQ4]
            dp_ff <= RST_DP_CTRL2; // [RQ7]
        end
        else
        begin
            high_ff <= nxt_high;
            low_ff <= nxt_low;
            dp_ff <= nxt_dp;
        end
    end

    // Read mux; unmapped offsets answer zero, tally is never stored
    always_comb
    begin
        nxt_rvalid = I_REG_RD;
        nxt_rdata = rdata_ff;
        if (I_REG_RD)
        begin
            case (I_REG_ADDR)
                ADDR_SELFTEST_TALLY: nxt_rdata = tally_sel; // [RQ1]
                ADDR_SCL_HIGH: nxt_rdata = high_ff;
                ADDR_SCL_LOW: nxt_rdata = low_ff;
                ADDR_DP_CTRL2: nxt_rdata = dp_ff & DP_WRITE_MASK; // [RQ12]
                default: nxt_rdata = BYTE_ZERO;
            endcase
        end
    end

    // Read answer registers
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RESET_N)
        begin
            rdata_ff <= RST_SELFTEST_TALLY;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Bus line level counts only when the last two stages agree
    always_comb
    begin
        nxt_scl_level = scl_level_ff;
        if (scl_s2_ff == scl_s3_ff)
        begin
            nxt_scl_level = scl_s3_ff;
        end
    end

    // Three-stage synchroniser on the open-drain clock pin
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RESET_N)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            scl_level_ff <= 1'b1;
        end
        else
        begin
            scl_s1_ff <= I_SCL_IN;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            scl_level_ff <= nxt_scl_level;
        end
    end

    // Timing settings handed to the clock generator and setup timer
    assign tif.high_per = high_ff;
    assign tif.low_per = low_ff;
    assign tif.master_en = I_SCL_MASTER_EN;
    assign tif.scl_level = scl_level_ff;
    assign tif.setup_start = I_SLV_DATA_READY;

    scl_master_gen u_scl_gen (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .tif(tif.gen),
        .o_scl_drive_low(scl_drive_low)
    );

    sda_setup_timer u_setup (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .tif(tif.gen),
        .o_hold_scl(slv_hold)
    );

    // Audio and pin routing; muting gates the data, not just the clock
    always_comb
    begin
        nxt_awclk = 1'b0;
        nxt_asdata = 1'b0;
        nxt_pin0 = I_PIN_ZERO_NORMAL;
        nxt_pin1 = I_PIN_ONE_NORMAL;
        if (dp_ff[BIT_ALT_AUDIO])
        begin
            nxt_pin1 = dp_ff[BIT_AUDIO_DIS] ? 1'b0 : I_AUDIO_WCLK; // [RQ9]
            nxt_pin0 = dp_ff[BIT_AUDIO_DIS] ? 1'b0 : I_AUDIO_SDATA; // [RQ9]
        end
        else if (!dp_ff[BIT_AUDIO_DIS])
        begin
            nxt_awclk = I_AUDIO_WCLK; // [RQ12]
            nxt_asdata = I_AUDIO_SDATA; // [RQ12]
        end
    end

    // Pin and audio output registers; control channel stays enabled
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RESET_N)
        begin
            pin0_ff <= 1'b0;
            pin1_ff <= 1'b0;
            awclk_ff <= 1'b0;
            asdata_ff <= 1'b0;
            ctrl_en_ff <= 1'b0;
        end
        else
        begin
            pin0_ff <= nxt_pin0;
            pin1_ff <= nxt_pin1;
            awclk_ff <= nxt_awclk;
            asdata_ff <= nxt_asdata;
            ctrl_en_ff <= 1'b1; // [RQ7]
        end
    end

    // Outputs, each straight from a register except O_SCL_O, which is tied to 0
    assign O_REG_RDATA = rdata_ff;
    assign O_REG_RVALID = rvalid_ff;
    assign O_SCL_O = 1'b0;
    assign O_SCL_OE = scl_drive_low;
    assign O_SLV_SCL_HOLD = slv_hold;
    assign O_GENERAL_PIN_ZERO = pin0_ff;
    assign O_GENERAL_PIN_ONE = pin1_ff;
    assign O_AUDIO_WCLK = awclk_ff;
    assign O_AUDIO_SDATA = asdata_ff;
    assign O_VIDEO_DISABLED = dp_ff[BIT_VID_DIS]; // [RQ7]
    assign O_DUAL_LINK = dp_ff[BIT_DUAL]; // [RQ8]
    assign O_SYNC_IN_STREAM = dp_ff[BIT_SYNC28]; // [RQ10]
    assign O_SURROUND_EN = dp_ff[BIT_SURROUND]; // [RQ11]
    assign O_CTRL_CHAN_EN = ctrl_en_ff;

    a_tally_select: assert property ( // [RQ1]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (I_REG_RD && I_REG_ADDR == ADDR_SELFTEST_TALLY)
        |=> (O_REG_RVALID && O_REG_RDATA == $past(tally_sel)))
        else $error("Tally read does not follow chosen port");
    a_tally_readonly: assert property ( // [RQ1]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (I_REG_WR && I_REG_ADDR == ADDR_SELFTEST_TALLY && !I_FC_LOAD)
        |=> ($stable(high_ff) && $stable(low_ff) && $stable(dp_ff)))
        else $error("Write to tally changed a register");
    a_high_reset: assert property ( // [RQ3]
        @(posedge I_CORE_CLK)
        !I_RESET_N |=> (high_ff == RST_SCL_HIGH && low_ff == RST_SCL_LOW))
        else $error("Period registers wrong after reset");
    a_video_reset: assert property ( // [RQ7]
        @(posedge I_CORE_CLK)
        !I_RESET_N ##1 I_RESET_N |-> (O_VIDEO_DISABLED ##1 O_CTRL_CHAN_EN))
        else $error("Video disabled or control channel wrong after reset");
    a_lock_keeps: assert property ( // [RQ6]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (I_FC_LOAD && dp_ff[BIT_LOCK] && !wr_dp) |=> $stable(dp_ff))
        else $error("Forward-channel load passed the lock");
    a_fc_loads: assert property ( // [RQ6]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (I_FC_LOAD && !dp_ff[BIT_LOCK] && !wr_dp)
        |=> ((dp_ff & DP_FC_MASK) == ($past(I_FC_DATA) & DP_FC_MASK)
             && dp_ff[BIT_LOCK] == 1'b0))
        else $error("Forward-channel load not applied");
    a_alt_pins: assert property ( // [RQ9]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (dp_ff[BIT_ALT_AUDIO] && !dp_ff[BIT_AUDIO_DIS])
        |=> (O_GENERAL_PIN_ONE == $past(I_AUDIO_WCLK)
             && O_GENERAL_PIN_ZERO == $past(I_AUDIO_SDATA)))
        else $error("Alternate audio not routed to general pins");
    a_audio_mute: assert property ( // [RQ12]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        dp_ff[BIT_AUDIO_DIS] |=> (!O_AUDIO_SDATA && !O_AUDIO_WCLK))
        else $error("Audio output not muted");
    a_rsvd_zero: assert property ( // [RQ12]
        @(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        (I_REG_RD && I_REG_ADDR == ADDR_DP_CTRL2)
        |=> (O_REG_RDATA[BIT_RSVD] == 1'b0 && !dp_ff[BIT_RSVD]))
        else $error("Reserved bit reads one");
endmodule

// file: hdl/deser_regs_pkg.sv
// Constants, field layout and state codes for the datapath register slice
package deser_regs_pkg;
    // Register offsets on the local register port
    localparam logic [7:0] ADDR_SELFTEST_TALLY = 8'h25;
    localparam logic [7:0] ADDR_SCL_HIGH = 8'h26;
    localparam logic [7:0] ADDR_SCL_LOW = 8'h27;
    localparam logic [7:0] ADDR_DP_CTRL2 = 8'h28;
    // Reset values
    localparam logic [7:0] RST_SELFTEST_TALLY = 8'h00;
    localparam logic [7:0] RST_SCL_HIGH = 8'h83;
    localparam logic [7:0] RST_SCL_LOW = 8'h84;
    localparam logic [7:0] RST_DP_CTRL2 = 8'h20;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Field positions of the datapath control register
    localparam int BIT_LOCK = 7;
    localparam int BIT_RSVD = 6;
    localparam int BIT_VID_DIS = 5;
    localparam int BIT_DUAL = 4;
    localparam int BIT_ALT_AUDIO = 3;
    localparam int BIT_AUDIO_DIS = 2;
    localparam int BIT_SYNC28 = 1;
    localparam int BIT_SURROUND = 0;
    // Reserved bit never stores; forward channel never touches the lock
    localparam logic [7:0] DP_WRITE_MASK = 8'hBF;
    localparam logic [7:0] DP_FC_MASK = 8'h3F;
    // Timing: one period field count is one oscillator unit
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_UNIT_NS = 50;
    localparam int CYCLES_PER_UNIT =
        (OSC_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 12;
    localparam logic [TICK_W-1:0] TICK_ZERO = {TICK_W{1'b0}};
    localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
    // State codes, one-hot
    typedef enum logic [2:0] {
        SCL_IDLE = 3'b001,
        SCL_LOW = 3'b010,
        SCL_HIGH = 3'b100
    } scl_state_t;
    typedef enum logic [1:0] {
        SETUP_IDLE = 2'b01,
        SETUP_WAIT = 2'b10
    } setup_state_t;
    // Field value to clock cycles, never less than one
    function automatic logic [TICK_W-1:0] to_ticks(input logic [7:0] field);
        logic [TICK_W-1:0] t;
        t = TICK_W'(field) * TICK_W'(CYCLES_PER_UNIT);
        if (t == TICK_ZERO)
        begin
            t = TICK_ONE;
        end
        return t;
    endfunction
endpackage

// file: hdl/scl_master_gen.sv
// Master clock generator: timed low and high phases, waits on stretching
`timescale 1ns/1ps
module scl_master_gen (
    input wire logic i_clk,
    input wire logic i_reset_n,
    scl_timing_if.gen tif,
    output logic o_scl_drive_low
);
    import deser_regs_pkg::*;
    scl_state_t state_ff, nxt_state;
    logic [TICK_W-1:0] cnt_ff, nxt_cnt;
    logic drive_ff, nxt_drive;
    logic [TICK_W-1:0] low_len_ff;

    // Phase sequencing; high time counts only once the line is seen high
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_drive = drive_ff;
        case (state_ff)
            SCL_IDLE:
            begin
                if (tif.master_en)
                begin
                    nxt_state = SCL_LOW;
                    nxt_drive = 1'b1;
                    nxt_cnt = to_ticks(tif.low_per) - TICK_ONE; // [RQ4]
                end
            end
            SCL_LOW:
            begin
                if (!tif.master_en)
                begin
                    nxt_state = SCL_IDLE;
                    nxt_drive = 1'b0;
                end
                else if (cnt_ff == TICK_ZERO)
                begin
                    nxt_state = SCL_HIGH;
                    nxt_drive = 1'b0;
                    nxt_cnt = to_ticks(tif.high_per) - TICK_ONE; // [RQ2]
                end
                else
                begin
                    nxt_cnt = cnt_ff - TICK_ONE;
                end
            end
            SCL_HIGH:
            begin
                if (!tif.master_en)
                begin
                    nxt_state = SCL_IDLE;
                end
                else if (!tif.scl_level)
                begin
                    nxt_cnt = cnt_ff; // Held low by a slave
                end
                else if (cnt_ff == TICK_ZERO)
                begin
                    nxt_state = SCL_LOW;
                    nxt_drive = 1'b1;
                    nxt_cnt = to_ticks(tif.low_per) - TICK_ONE; // [RQ4]
                end
                else
                begin
                    nxt_cnt = cnt_ff - TICK_ONE; // [RQ2]
                end
            end
            default:
            begin
                nxt_state = SCL_IDLE;
                nxt_drive = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            state_ff <= SCL_IDLE;
            cnt_ff <= TICK_ZERO;
            drive_ff <= 1'b0;
            low_len_ff <= TICK_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            drive_ff <= nxt_drive;
            low_len_ff <= drive_ff ? low_len_ff + TICK_ONE : TICK_ZERO;
        end
    end

    assign o_scl_drive_low = drive_ff;

    a_low_width: assert property ( // [RQ4]
        @(posedge i_clk) disable iff (!i_reset_n)
        ($fell(drive_ff) && $past(tif.master_en) && $stable(tif.low_per))
        |-> (low_len_ff == to_ticks(tif.low_per)))
        else $error("SCL low phase length differs from low period");
    a_high_after_low: assert property ( // [RQ2]
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_ff == SCL_LOW && cnt_ff == TICK_ZERO && tif.master_en)
        |=> (state_ff == SCL_HIGH && !drive_ff
             && cnt_ff == to_ticks($past(tif.high_per)) - TICK_ONE))
        else $error("High phase not loaded from high period");
endmodule

// file: hdl/scl_timing_if.sv
// Timing settings shared by the clock generator and the setup timer
`timescale 1ns/1ps
interface scl_timing_if;
    logic [7:0] high_per;
    logic [7:0] low_per;
    logic master_en;
    logic scl_level;
    logic setup_start;
    modport ctl (output high_per, low_per, master_en, scl_level, setup_start);
    modport gen (input high_per, low_per, master_en, scl_level, setup_start);
endinterface

// file: hdl/sda_setup_timer.sv
// Slave-side setup timer: keeps the clock stretched while data settles
`timescale 1ns/1ps
module sda_setup_timer (
    input wire logic i_clk,
    input wire logic i_reset_n,
    scl_timing_if.gen tif,
    output logic o_hold_scl
);
    import deser_regs_pkg::*;
    setup_state_t state_ff, nxt_state;
    logic [TICK_W-1:0] cnt_ff, nxt_cnt;
    logic hold_ff, nxt_hold;

    // A new start while waiting is ignored; the first one sets the pace
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_hold = hold_ff;
        case (state_ff)
            SETUP_IDLE:
            begin
                if (tif.setup_start)
                begin
                    nxt_state = SETUP_WAIT;
                    nxt_hold = 1'b1;
                    nxt_cnt = to_ticks(tif.low_per) - TICK_ONE; // [RQ5]
                end
            end
            SETUP_WAIT:
            begin
                if (cnt_ff == TICK_ZERO)
                begin
                    nxt_state = SETUP_IDLE;
                    nxt_hold = 1'b0; // [RQ5]
                end
                else
                begin
                    nxt_cnt = cnt_ff - TICK_ONE;
                end
            end
            default:
            begin
                nxt_state = SETUP_IDLE;
                nxt_hold = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            state_ff <= SETUP_IDLE;
            cnt_ff <= TICK_ZERO;
            hold_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
        end
    end

    assign o_hold_scl = hold_ff;

    a_setup_start: assert property ( // [RQ5]
        @(posedge i_clk) disable iff (!i_reset_n)
        (tif.setup_start && state_ff == SETUP_IDLE)
        |=> (hold_ff && cnt_ff == to_ticks($past(tif.low_per)) - TICK_ONE))
        else $error("Setup hold not started from low period");
endmodule

// file: verification/scl_bus_model.sv
// Clock wire with pull-up and a far device that may stretch it low
`timescale 1ns/1ps
module scl_bus_model (
    input wire logic i_clk,
    input wire logic i_oe,
    input wire logic [7:0] i_stretch,
    output logic o_scl
);
    logic [7:0] left_ff = 8'h00;
    // Stretch is armed while the device pulls low, runs out after release
    always_ff @(posedge i_clk)
    begin
        if (i_oe)
        begin
            left_ff <= i_stretch;
        end
        else if (left_ff != 8'h00)
        begin
            left_ff <= left_ff - 8'h01;
        end
    end
    // Pull-up wins only when nobody holds the wire low
    assign o_scl = !(i_oe || left_ff != 8'h00);
endmodule

// file: verification/testbench.sv
// Self-checking bench for the datapath register slice
`timescale 1ns/1ps
module testbench;
    import deser_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, fc_data = 8'h00;
    logic [7:0] t0 = 8'h00, t1 = 8'h00, stretch = 8'h00;
    logic wr = 1'b0, rd = 1'b0, fc_load = 1'b0, port_sel = 1'b0;
    logic m_en = 1'b0, rdy = 1'b0, wclk = 1'b0, sdata = 1'b0;
    logic pz = 1'b0, po = 1'b0;
    logic [7:0] rdata;
    logic rvalid, scl_o, scl_oe, hold, g0, g1, aw, ad, scl;
    logic vdis, dual, sync, surr, cce;
    int errors = 0, n_checks = 0, cycles = 0, k;
    logic [7:0] seed = 8'h12, v, d, exp_dp;

    deser_bist_i2c_datapath_regs dut (
        .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr),
        .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_FC_LOAD(fc_load),
        .I_FC_DATA(fc_data), .I_SECOND_PORT_CHOICE(port_sel),
        .I_TALLY_PORT0(t0), .I_TALLY_PORT1(t1), .I_SCL_MASTER_EN(m_en),
        .I_SCL_IN(scl), .O_SCL_O(scl_o), .O_SCL_OE(scl_oe),
        .I_SLV_DATA_READY(rdy), .O_SLV_SCL_HOLD(hold),
        .I_AUDIO_WCLK(wclk), .I_AUDIO_SDATA(sdata),
        .I_PIN_ZERO_NORMAL(pz), .I_PIN_ONE_NORMAL(po),
        .O_GENERAL_PIN_ZERO(g0), .O_GENERAL_PIN_ONE(g1),
        .O_AUDIO_WCLK(aw), .O_AUDIO_SDATA(ad), .O_VIDEO_DISABLED(vdis),
        .O_DUAL_LINK(dual), .O_SYNC_IN_STREAM(sync),
        .O_SURROUND_EN(surr), .O_CTRL_CHAN_EN(cce)
    );
    scl_bus_model far_end (
        .i_clk(clk), .i_oe(scl_oe), .i_stretch(stretch), .o_scl(scl)
    );

    // Free-running core clock, 50 ns period
    always #25 clk = ~clk;

    task automatic report_and_stop();
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Eight-bit shift-register sequence, repeatable from its seed
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    // Lock set keeps the register; otherwise the low six bits load
    function automatic logic [7:0] fc_exp(input logic [7:0] c, f);
        return c[7] ? c : {2'b00, f[5:0]};
    endfunction

    // Expected {pin one, pin zero, word clock, data} from x
    function automatic logic [3:0] aud_exp(input logic alt, dis,
                                           input logic [3:0] x);
        if (alt)
            return {x[3] & ~dis, x[2] & ~dis, 2'b00};
        return {x[0], x[1], dis ? 2'b00 : x[3:2]};
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Answer stands one cycle after the strobe edge, sampled there
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(8'(rvalid), 8'h01);
        dat = rdata;
    endtask

    // Counts cycles while the chosen output stays at lvl
    task automatic span(input logic use_hold, input logic lvl);
        k = 0;
        while ((use_hold ? hold : scl_oe) === lvl && k < 400)
        begin
            k++;
            @(posedge clk);
            #1;
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_SCL_HIGH, v);
        check(v, 8'h83);
        reg_rd(ADDR_SCL_LOW, v);
        check(v, 8'h84);
        reg_rd(ADDR_DP_CTRL2, v);
        check(v, 8'h20);
        check(8'({vdis, cce}), 8'h03);
        reg_rd(8'h3C, v);
        check(v, 8'h00);
        // Tally follows the chosen port and ignores writes
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            t0 <= rnd();
            t1 <= rnd();
            port_sel <= i[0];
            reg_wr(ADDR_SELFTEST_TALLY, 8'h5A);
            reg_rd(ADDR_SELFTEST_TALLY, v);
            check(v, port_sel ? t1 : t0);
        end
        // Timing fields store any byte
        for (int i = 0; i < 4; i++)
        begin
            d = rnd();
            reg_wr(ADDR_SCL_HIGH, d);
            reg_wr(ADDR_SCL_LOW, ~d);
            reg_rd(ADDR_SCL_HIGH, v);
            check(v, d);
            reg_rd(ADDR_SCL_LOW, v);
            check(v, ~d);
        end
        reg_wr(ADDR_DP_CTRL2, 8'h7F);
        reg_rd(ADDR_DP_CTRL2, v);
        check(v, 8'h3F);
        exp_dp = 8'h3F;
        // Forward loads, then the same with the lock set
        for (int i = 0; i < 6; i++)
        begin
            if (i == 3)
            begin
                reg_wr(ADDR_DP_CTRL2, 8'hD5);
                exp_dp = 8'h95;
            end
            @(posedge clk);
            fc_data <= (i == 0) ? 8'hFF : rnd();
            fc_load <= 1'b1;
            @(posedge clk);
            fc_load <= 1'b0;
            exp_dp = fc_exp(exp_dp, fc_data);
            reg_rd(ADDR_DP_CTRL2, v);
            check(v, exp_dp);
            check(8'({vdis, dual}), 8'(exp_dp[5:4]));
            check(8'({sync, surr}), 8'(exp_dp[1:0]));
        end
        // Every alternate-routing and mute combination
        for (int i = 0; i < 8; i++)
        begin
            reg_wr(ADDR_DP_CTRL2, {4'h0, i[1:0], 2'b00});
            v = rnd();
            {wclk, sdata, pz, po} <= v[3:0];
            repeat (2) @(posedge clk);
            #1;
            d = 8'(aud_exp(i[1], i[0], v[3:0]));
            check(8'({g1, g0, aw, ad}), d);
        end
        // Local write and forward load in one cycle: the write wins
        @(posedge clk);
        addr <= ADDR_DP_CTRL2;
        wdata <= 8'h11;
        fc_data <= 8'h2A;
        wr <= 1'b1;
        fc_load <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        fc_load <= 1'b0;
        reg_rd(ADDR_DP_CTRL2, v);
        check(v, 8'h11);
        // Master clock, prompt and slow far end
        reg_wr(ADDR_SCL_HIGH, 8'h04);
        reg_wr(ADDR_SCL_LOW, 8'h05);
        @(posedge clk);
        m_en <= 1'b1;
        for (int s = 0; s < 24; s += 12)
        begin
            stretch <= 8'(s);
            span(1'b0, 1'b0);
            span(1'b0, 1'b1);
            check(8'(k), 8'h05);
            check(8'(scl_o), 8'h00);
            span(1'b0, 1'b0);
            check(8'(k >= 4 + s && k <= 12 + s), 8'h01);
        end
        @(posedge clk);
        m_en <= 1'b0;
        // Slave setup wait lasts the low field, for fields 1 and 7
        for (int i = 1; i < 9; i += 6)
        begin
            reg_wr(ADDR_SCL_LOW, 8'(i));
            @(posedge clk);
            rdy <= 1'b1;
            @(posedge clk);
            rdy <= 1'b0;
            #1;
            span(1'b1, 1'b1);
            check(8'(k), 8'(i));
        end
        report_and_stop();
    end
endmodule
